// ===== common/drive_io_map.svh
// Constants for the drive digital terminal block: timing, codes, resets.
// Assumes a 125 MHz system clock; included by the package and the RTL.
`ifndef DRIVE_IO_MAP_SVH
`define DRIVE_IO_MAP_SVH
`define CLK_PERIOD_NS 8
`define TICK_TIME_NS 1000000
`define TICK_CYCLES (`TICK_TIME_NS / `CLK_PERIOD_NS)
`define DELAY_MAX_MS 16'd50000
`define DELAY_RST_MS 16'h0000
`define DI_RST 16'h0000
`define NUM_DI 5
`define NUM_DO 4
`define MODE_2W_A 2'h0
`define MODE_2W_B 2'h1
`define MODE_3W_A 2'h2
`define MODE_3W_B 2'h3
`define FN_INVALID 5'h00
`define FN_RUN 5'h01
`define FN_FWD 5'h02
`define FN_REV 5'h03
`define FN_JOG 5'h04
`define FN_FAULT 5'h05
`define FN_FDT_A 5'h06
`define FN_FDT_B 5'h07
`define FN_REACHED 5'h08
`define FN_ZERO 5'h09
`define FN_UPPER 5'h0a
`define FN_LOWER 5'h0b
`define FN_READY 5'h0c
`define FN_PREEXC 5'h0d
`define FN_OVERLOAD 5'h0e
`define FN_UNDERLOAD 5'h0f
`define FN_SEQ_STAGE 5'h10
`define FN_SEQ_CYCLE 5'h11
`define DO_FAST 3
`endif

// ===== common/drive_io_pkg.sv
// Types shared by the drive digital terminal block and its bench.
// Assumes drive_io_map.svh is on the include path.
`include "drive_io_map.svh"
package drive_io_pkg;
	typedef enum logic [1:0] {
		TWO_WIRE_A = 2'b00,
		TWO_WIRE_B = 2'b01,
		THREE_WIRE_A = 2'b10,
		THREE_WIRE_B = 2'b11
	} term_mode_t;
	typedef struct packed {
		logic [15:0] on_ms;
		logic [15:0] off_ms;
	} delay_cfg_t;
	typedef struct packed {
		logic running;
		logic dir_reverse;
		logic jogging;
		logic out_freq_zero;
		logic ref_freq_zero;
		logic fault;
		logic freq_level_detect_a;
		logic freq_level_detect_b;
		logic freq_reached;
		logic upper_limit;
		logic lower_limit;
		logic main_power_ok;
		logic ctrl_power_ok;
		logic protection_active;
		logic ready_to_run;
		logic pre_exciting;
		logic overload_alarm;
		logic underload_alarm;
		logic seq_stage_done;
		logic seq_cycle_done;
	} drive_status_t;
	typedef struct packed {
		logic fwd;
		logic rev;
	} run_cmd_t;
endpackage

// ===== rtl/drive_digital_terminal_io.sv
// Digital terminal logic of a motor drive: delayed switch inputs,
// terminal run-command decode, fault snapshot, four function outputs.
// Assumes all inputs are synchronous to CLK; settings are held stable.
//
// Functional notes
// - Each switch input has its own on delay, 0 to 50000 ms, default 0.
// - Each switch input has its own off delay, 0 to 50000 ms, default 0.
// - Mode 3 selects the second three-wire run scheme.
// - Modes 0 and 1 are two-wire schemes, 2 is three-wire; default 0.
// - Input state is captured at a fault and held; reset value zero.
// - Present 16-bit input state is readable; reset value zero.
// - Two relays, one open-collector, one pulse output, each programmable.
// - Pulse output acts as pulse generator or plain on/off output.
// - One function code may drive several outputs at once.
// - Invalid function code keeps an output inactive.
// - Function codes 0 to 17 are numbered as the code table lists.
// - Running asserts when running with nonzero output frequency.
// - Forward or reverse asserts with frequency in that direction.
// - Jogging asserts with output frequency during jog.
// - Fault asserts while the drive is in fault.
// - Zero speed asserts when output and reference frequency are zero.
// - Upper limit asserts when running frequency reaches upper limit.
// - Lower limit asserts when running frequency reaches lower limit.
// - Ready needs both powers, no protection active, ready to run.
// - Pre-exciting asserts during motor pre-excitation.
// - Overload pre-alarm follows the timed overload alarm.
// - Underload pre-alarm follows the timed underload alarm.
// - Sequencer-stage signals each completed stage.
// - Sequencer-cycle signals each completed cycle.
`timescale 1ns/1ps
`include "drive_io_map.svh"
module drive_digital_terminal_io #(
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	input wire logic CLK, // 125 MHz system clock
	input wire logic RESET_N, // Asynchronous reset, active low
	input wire logic [`NUM_DI-1:0] SW_IN, // Raw inputs, bit 4 is fast input
	input wire drive_io_pkg::delay_cfg_t [`NUM_DI-1:0] DELAY_CFG, // Per input
	input wire drive_io_pkg::term_mode_t TERM_MODE, // Run-command scheme
	input wire drive_io_pkg::drive_status_t STATUS, // Drive state
	input wire logic [`NUM_DO-1:0][4:0] FUNC_SEL, // Function per output
	input wire logic FAST_PULSE_MODE, // 1: pulse generator
	input wire logic [15:0] PULSE_HALF, // Half period, clocks
	output logic [15:0] DI_STATE, // Accepted input state
	output logic [15:0] FAULT_DI_STATE, // State captured at fault
	output drive_io_pkg::run_cmd_t RUN_CMD, // Decoded run command
	output logic [`NUM_DO-1:0] DOUT // Relay 1, relay 2, OC, fast
);

	////////////////////////////////////////////////////////////////////
	// Millisecond tick from the system clock
	logic [16:0] tick_cnt_q;
	logic tick_q;
	wire tick_wrap = (tick_cnt_q == 17'(TICK_CYCLES - 1));

	// Single-cycle enable; all delays count in these ticks
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			tick_cnt_q <= 17'h00000;
			tick_q <= 1'b0;
		end
		else
		begin
			tick_cnt_q <= tick_wrap ? 17'h00000 : tick_cnt_q + 17'h00001;
			tick_q <= tick_wrap;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Switch input delays
	logic [`NUM_DI-1:0] acc_q;
	genvar gi;
	generate
		for (gi = 0; gi < `NUM_DI; gi++)
		begin : g_di
			logic [15:0] cnt_q;
			wire differ = SW_IN[gi] != acc_q[gi];
			wire [15:0] lim = SW_IN[gi] ? DELAY_CFG[gi].on_ms : DELAY_CFG[gi].off_ms;
			wire done = differ && (lim == 16'h0000 || cnt_q > lim);

			// A reversal before the limit clears the count, so a
			// bounce shorter than the delay never gets through
			always_ff @(posedge CLK or negedge RESET_N)
			begin
				if (!RESET_N)
				begin
					cnt_q <= `DELAY_RST_MS;
					acc_q[gi] <= 1'b0;
				end
				else
				begin
					if (!differ || done)
						cnt_q <= 16'h0000;
					else if (tick_q)
						cnt_q <= cnt_q + 16'h0001;
					if (done)
						acc_q[gi] <= SW_IN[gi];
				end
			end

			// Zero delay passes a change on the next edge
			AST_ZERO_DELAY: assert property (@(posedge CLK) disable iff (!RESET_N)
				(differ && lim == 16'h0000) |=> acc_q[gi] == $past(SW_IN[gi]))
				else $error("zero delay not immediate");
			AST_NO_EARLY: assert property (@(posedge CLK) disable iff (!RESET_N)
				(differ && cnt_q < lim) |=> acc_q[gi] == $past(acc_q[gi]))
				else $error("input accepted before delay");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Input state and fault snapshot
	logic fault_q;
	wire [15:0] di_word = {11'h000, acc_q};
	wire fault_rise = STATUS.fault && !fault_q;

	// Snapshot taken on the fault's first cycle only, so the value
	// stays put while the drive sits in fault
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			DI_STATE <= `DI_RST;
			FAULT_DI_STATE <= `DI_RST;
			fault_q <= 1'b0;
		end
		else
		begin
			DI_STATE <= di_word;
			fault_q <= STATUS.fault;
			if (fault_rise)
				FAULT_DI_STATE <= DI_STATE;
		end
	end

	AST_FAULT_SNAP: assert property (@(posedge CLK) disable iff (!RESET_N)
		fault_rise |=> FAULT_DI_STATE == $past(DI_STATE))
		else $error("fault snapshot wrong");
	AST_FAULT_HOLD: assert property (@(posedge CLK) disable iff (!RESET_N)
		!fault_rise |=> $stable(FAULT_DI_STATE))
		else $error("fault snapshot changed");

	////////////////////////////////////////////////////////////////////
	// Terminal run-command decode
	// Inputs 1 and 2 give forward/run and reverse/direction, input 3
	// is the normally closed stop for the three-wire schemes.
	logic hold_fwd_q;
	logic hold_rev_q;
	wire in1 = acc_q[0];
	wire in2 = acc_q[1];
	wire stop_n = acc_q[2];
	wire two_a = TERM_MODE == drive_io_pkg::TWO_WIRE_A;
	wire two_b = TERM_MODE == drive_io_pkg::TWO_WIRE_B;
	wire three_a = TERM_MODE == drive_io_pkg::THREE_WIRE_A;
	wire three_b = TERM_MODE == drive_io_pkg::THREE_WIRE_B;
	// Both run inputs in two-wire scheme A cancel each other to a stop
	wire fwd_2w = (two_a && in1 && !in2) || (two_b && in1 && !in2);
	wire rev_2w = (two_a && in2 && !in1) || (two_b && in1 && in2);
	wire set_fwd = (three_a && in1) || (three_b && in1 && !in2);
	wire set_rev = (three_a && in2 && !in1) || (three_b && in1 && in2);
	drive_io_pkg::run_cmd_t cmd_d;
	assign cmd_d.fwd = two_a || two_b ? fwd_2w : hold_fwd_q;
	assign cmd_d.rev = two_a || two_b ? rev_2w : hold_rev_q;

	// Three-wire latches: a pulse sets, an open stop contact clears;
	// stop wins so a held run button cannot override it
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			hold_fwd_q <= 1'b0;
			hold_rev_q <= 1'b0;
			RUN_CMD <= '0;
		end
		else
		begin
			if (!stop_n || two_a || two_b)
			begin
				hold_fwd_q <= 1'b0;
				hold_rev_q <= 1'b0;
			end
			else if (set_fwd)
			begin
				hold_fwd_q <= 1'b1;
				hold_rev_q <= 1'b0;
			end
			else if (set_rev)
			begin
				hold_fwd_q <= 1'b0;
				hold_rev_q <= 1'b1;
			end
			RUN_CMD <= cmd_d;
		end
	end

	AST_THREE_STOP: assert property (@(posedge CLK) disable iff (!RESET_N)
		(three_b && !stop_n) ##1 three_b |=> RUN_CMD == '0)
		else $error("three-wire stop ignored");
	AST_TWO_FWD: assert property (@(posedge CLK) disable iff (!RESET_N)
		(two_a && in1 && !in2) |=> RUN_CMD.fwd && !RUN_CMD.rev)
		else $error("two-wire forward wrong");

	////////////////////////////////////////////////////////////////////
	// Output function selection
	logic stage_q;
	logic cycle_q;

	// Sequencer events are pulses; hold them until the next tick so a
	// pulse between ticks still reaches the outputs. Set wins over clear.
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			stage_q <= 1'b0;
			cycle_q <= 1'b0;
		end
		else
		begin
			stage_q <= STATUS.seq_stage_done || (stage_q && !tick_q);
			cycle_q <= STATUS.seq_cycle_done || (cycle_q && !tick_q);
		end
	end

	function automatic logic func_mux(input logic [4:0] code,
		input drive_io_pkg::drive_status_t s, input logic stg, input logic cyc);
		logic freq;
		freq = s.running && !s.out_freq_zero;
		unique case (code)
			`FN_INVALID: func_mux = 1'b0;
			`FN_RUN: func_mux = freq;
			`FN_FWD: func_mux = freq && !s.dir_reverse;
			`FN_REV: func_mux = freq && s.dir_reverse;
			`FN_JOG: func_mux = freq && s.jogging;
			`FN_FAULT: func_mux = s.fault;
			`FN_FDT_A: func_mux = s.freq_level_detect_a;
			`FN_FDT_B: func_mux = s.freq_level_detect_b;
			`FN_REACHED: func_mux = s.freq_reached;
			`FN_ZERO: func_mux = s.out_freq_zero && s.ref_freq_zero;
			`FN_UPPER: func_mux = s.upper_limit;
			`FN_LOWER: func_mux = s.lower_limit;
			`FN_READY: func_mux = s.main_power_ok && s.ctrl_power_ok
				&& !s.protection_active && s.ready_to_run;
			`FN_PREEXC: func_mux = s.pre_exciting;
			`FN_OVERLOAD: func_mux = s.overload_alarm;
			`FN_UNDERLOAD: func_mux = s.underload_alarm;
			`FN_SEQ_STAGE: func_mux = stg;
			`FN_SEQ_CYCLE: func_mux = cyc;
			default: func_mux = 1'b0; // Unused codes behave as invalid
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////
	// Fast output pulse generator
	logic [15:0] pulse_cnt_q;
	logic pulse_q;
	wire pulse_wrap = pulse_cnt_q + 16'h0001 >= PULSE_HALF;

	// Square wave at twice PULSE_HALF clocks; zero parks it low
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			pulse_cnt_q <= 16'h0000;
			pulse_q <= 1'b0;
		end
		else if (!FAST_PULSE_MODE || PULSE_HALF == 16'h0000)
		begin
			pulse_cnt_q <= 16'h0000;
			pulse_q <= 1'b0;
		end
		else
		begin
			pulse_cnt_q <= pulse_wrap ? 16'h0000 : pulse_cnt_q + 16'h0001;
			if (pulse_wrap)
				pulse_q <= !pulse_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Output terminals
	logic [`NUM_DO-1:0] sel_w;
	generate
		for (gi = 0; gi < `NUM_DO; gi++)
		begin : g_do
			// Each terminal decodes its own code, so codes may repeat
			assign sel_w[gi] = func_mux(FUNC_SEL[gi], STATUS, stage_q, cycle_q);

			// Refresh on the tick only; the fast output in pulse mode
			// bypasses the tick so its rate is not quantised
			always_ff @(posedge CLK or negedge RESET_N)
			begin
				if (!RESET_N)
					DOUT[gi] <= 1'b0;
				else if (gi == `DO_FAST && FAST_PULSE_MODE)
					DOUT[gi] <= pulse_q;
				else if (tick_q)
					DOUT[gi] <= sel_w[gi];
			end
		end
	endgenerate

	// Default clocking for the output checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	AST_INVALID_LOW: assert property (
		(tick_q && FUNC_SEL[0] == `FN_INVALID) |=> !DOUT[0])
		else $error("invalid function drove output");
	AST_SAME_CODE: assert property (
		(tick_q && FUNC_SEL[0] == FUNC_SEL[1]) |=> DOUT[0] == DOUT[1])
		else $error("shared code diverged");
	AST_READY: assert property (
		(tick_q && FUNC_SEL[1] == `FN_READY && STATUS.protection_active)
		|=> !DOUT[1])
		else $error("ready with protection active");
	AST_HOLD_BETWEEN: assert property (
		(!tick_q && !(FAST_PULSE_MODE)) |=> $stable(DOUT))
		else $error("output changed off tick");
	sequence s_stage_pulse;
		STATUS.seq_stage_done && !tick_q && FUNC_SEL[2] == `FN_SEQ_STAGE;
	endsequence
	sequence s_stage_tick;
		tick_q && stage_q && FUNC_SEL[2] == `FN_SEQ_STAGE;
	endsequence
	AST_STAGE_SEEN: assert property (s_stage_pulse |=> stage_q)
		else $error("stage event lost");
	AST_STAGE_OUT: assert property (s_stage_tick |=> DOUT[2])
		else $error("stage event not driven");
	AST_ZERO_SPEED: assert property (
		(tick_q && FUNC_SEL[2] == `FN_ZERO && !STATUS.ref_freq_zero) |=> !DOUT[2])
		else $error("zero speed with reference set");

endmodule

// ===== test/drive_digital_terminal_io_test.sv
// Self-checking bench for the drive digital terminal block.
// Assumes the package and map header; ticks shortened to 20 clocks.
`timescale 1ns/1ps
`include "drive_io_map.svh"
module drive_digital_terminal_io_test;
	localparam int TK = 20;
	localparam logic [6:0] RUNTAB [0:17] = '{7'b00_001_10, 7'b00_010_01, 7'b00_011_00,
		7'b00_000_00, 7'b01_001_10, 7'b01_011_01, 7'b01_010_00, 7'b01_000_00,
		7'b10_101_10, 7'b10_100_10, 7'b10_110_01, 7'b10_000_00, 7'b10_001_00,
		7'b11_101_10, 7'b11_100_10, 7'b11_000_00, 7'b11_001_00, 7'b00_000_00};
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [4:0] level = '0;
	logic [4:0] chatter = '0;
	logic [4:0] sw;
	drive_io_pkg::delay_cfg_t [4:0] dcfg = '0;
	drive_io_pkg::term_mode_t mode = drive_io_pkg::TWO_WIRE_A;
	drive_io_pkg::drive_status_t st = '0;
	logic [3:0][4:0] fsel = '0;
	logic pmode = 1'b0;
	logic [15:0] phalf = 16'h0005;
	logic [15:0] di;
	logic [15:0] fdi;
	drive_io_pkg::run_cmd_t rc;
	logic [3:0] dout;
	logic [3:0] load;
	logic [3:0] ev;
	logic [4:0] r;
	int miscompares = 0;
	int comparisons = 0;
	int cyc = 0;
	int n;
	int on;
	int off;
	////////////////////////////////////////////////////////////////////////////
	field_wiring wiring (.level(level), .chatter(chatter), .dout(dout), .sw_in(sw),
		.load_on(load));
	drive_digital_terminal_io #(.TICK_CYCLES(TK)) DUT (.CLK(clk), .RESET_N(reset_n),
		.SW_IN(sw), .DELAY_CFG(dcfg), .TERM_MODE(mode), .STATUS(st), .FUNC_SEL(fsel),
		.FAST_PULSE_MODE(pmode), .PULSE_HALF(phalf), .DI_STATE(di),
		.FAULT_DI_STATE(fdi), .RUN_CMD(rc), .DOUT(dout));
	////////////////////////////////////////////////////////////////////////////
	// Clock, and a cycle ceiling well above the whole run of about 4400 cycles
	initial
	begin
		forever #4 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			miscompares++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Reference for one output: code selects a condition, unknown codes stay off
	function automatic logic exp_fn(logic [4:0] c, drive_io_pkg::drive_status_t s);
		logic mv;
		mv = s.running && !s.out_freq_zero;
		case (c)
			`FN_RUN: return mv;
			`FN_FWD: return mv && !s.dir_reverse;
			`FN_REV: return mv && s.dir_reverse;
			`FN_JOG: return mv && s.jogging;
			`FN_FAULT: return s.fault;
			`FN_FDT_A: return s.freq_level_detect_a;
			`FN_FDT_B: return s.freq_level_detect_b;
			`FN_REACHED: return s.freq_reached;
			`FN_ZERO: return s.out_freq_zero && s.ref_freq_zero;
			`FN_UPPER: return s.upper_limit;
			`FN_LOWER: return s.lower_limit;
			`FN_READY: return s.main_power_ok && s.ctrl_power_ok && !s.protection_active
				&& s.ready_to_run;
			`FN_PREEXC: return s.pre_exciting;
			`FN_OVERLOAD: return s.overload_alarm;
			`FN_UNDERLOAD: return s.underload_alarm;
			`FN_SEQ_STAGE: return s.seq_stage_done;
			`FN_SEQ_CYCLE: return s.seq_cycle_done;
			default: return 1'b0;
		endcase
	endfunction
	// Shared tally behind the compare tasks
	task automatic tally(string w, logic [15:0] e, logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic check_state(string w, logic [15:0] e, logic [15:0] g);
		tally(w, e, g);
	endtask
	task automatic check_run(logic [1:0] e);
		tally("run command", 16'(e), 16'(rc));
	endtask
	task automatic check_out(logic [3:0] e);
		tally("outputs", 16'(e), 16'(dout));
		tally("loads", 16'(e), 16'(load));
	endtask
	// Bounded wait for one accepted input bit
	task automatic wait_bit(int i, logic v, int lim);
		n = 0;
		while (di[i] !== v && n < lim)
		begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic conclude();
		$display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Main sequence; inputs change on the falling edge only
	initial
	begin
		void'($urandom(50));
		repeat (4) @(negedge clk);
		check_state("reset state", 16'h0000, di | fdi | 16'(rc) | 16'(dout));
		reset_n = 1'b1;
		// Delays: a chatter mid-wait restarts the count, both edges timed
		for (int i = 0; i < 5; i++)
		begin
			on = $urandom_range(4, 6);
			off = $urandom_range(2, 4);
			dcfg[i] = {16'(on), 16'(off)};
			level[i] = 1'b1;
			repeat ((on - 1) * TK - 2) @(negedge clk);
			check_state("early on", 16'h0000, 16'(di[i]));
			chatter[i] = 1'b1;
			@(negedge clk);
			chatter[i] = 1'b0;
			repeat ((on - 1) * TK - 2) @(negedge clk);
			check_state("restart", 16'h0000, 16'(di[i]));
			wait_bit(i, 1'b1, 3 * TK);
			check_state("accepted on", 16'(level), di);
			level[i] = 1'b0;
			repeat ((off - 1) * TK - 2) @(negedge clk);
			check_state("early off", 16'h0001, 16'(di[i]));
			wait_bit(i, 1'b0, 3 * TK);
			check_state("accepted off", 16'h0000, di);
		end
		$display("delay test done");
		// Fault snapshot, no recapture while the fault stays
		dcfg = '0;
		r = 5'($urandom);
		level = r;
		repeat (5) @(negedge clk);
		check_state("live state", 16'(r), di);
		st.fault = 1'b1;
		repeat (3) @(negedge clk);
		check_state("snapshot", 16'(r), fdi);
		level = ~r;
		repeat (5) @(negedge clk);
		check_state("held snapshot", 16'(r), fdi);
		st.fault = 1'b0;
		@(negedge clk);
		st.fault = 1'b1;
		repeat (3) @(negedge clk);
		check_state("second snapshot", {11'h000, ~r}, fdi);
		st.fault = 1'b0;
		level = '0;
		$display("fault test done");
		// Run-command schemes, every mode in turn
		foreach (RUNTAB[k])
		begin
			mode = drive_io_pkg::term_mode_t'(RUNTAB[k][6:5]);
			level[2:0] = RUNTAB[k][4:2];
			repeat (6) @(negedge clk);
			check_run(RUNTAB[k][1:0]);
		end
		$display("mode test done");
		// Output functions on random drive state, sometimes one code on all four
		for (int k = 0; k < 48; k++)
		begin
			st = drive_io_pkg::drive_status_t'(20'($urandom));
			for (int j = 0; j < 4; j++)
				fsel[j] = (k % 4 == 0) ? 5'(k / 4 + 6) : 5'($urandom_range(0, 19));
			repeat (3 * TK) @(negedge clk);
			for (int j = 0; j < 4; j++)
				ev[j] = exp_fn(fsel[j], st);
			check_out(ev);
		end
		$display("output test done");
		// Fast output as a pulse generator, ignoring its code
		fsel[3] = `FN_INVALID;
		pmode = 1'b1;
		repeat (3 * TK) @(negedge clk);
		r[0] = dout[`DO_FAST];
		wait_pulse();
		r[0] = dout[`DO_FAST];
		wait_pulse();
		check_state("pulse half", phalf, 16'(n));
		pmode = 1'b0;
		$display("pulse test done");
		conclude();
	end
	// Clocks until the fast output leaves the level held in r[0]
	task automatic wait_pulse();
		n = 0;
		while (dout[`DO_FAST] === r[0] && n < 40)
		begin
			@(negedge clk);
			n++;
		end
	endtask
endmodule

// ===== test/field_wiring.sv
// Field wiring model: switch contacts that can chatter, loads on the outputs.
// Assumes the bench sets contact levels away from the rising clock edge.
`timescale 1ns/1ps
module field_wiring (
	input wire logic [4:0] level, // Intended contact state
	input wire logic [4:0] chatter, // Contact bounce, flips a line
	input wire logic [3:0] dout, // Terminal outputs of the drive
	output logic [4:0] sw_in, // Lines seen by the drive
	output logic [3:0] load_on // Loads pulled in by the outputs
);
	////////////////////////////////////////////////////////////////////////////
	// A bouncing contact shows the opposite level while it chatters
	assign sw_in = level ^ chatter;
	// Relays and open collector alike energise their load on a high output
	assign load_on = dout;
endmodule
